// ===== verilog/adc_conversion_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Transfer to result registers sets complete flag.
// - Flag set with enable high raises interrupt.
// - 10-bit split read blocks and discards result.
// - Single compare-false conversion just terminates.
// - Other blocked transfers restart a conversion.
// - Control-one write aborts, restarts unless disabled.
// - Mode register writes abort current conversion.
// - Reset or stop without async clock aborts.
// - Non-reset abort keeps last results.
// - Reset returns results to reset values.
// - Idle until started; async clock only when needed.
// - Low-power bit selects reduced-power operation.
// - Sample short or long, then approximate.
// - Four conversion clock sources.
// - Alternate clock works in wait, not stop.
// - Hardware trigger starts conversion per overflow.
// - Trigger independent of counter interrupt enable.
// - Trigger works in run, wait, shallow stop.
// - 10-bit gives 1024 codes, 8-bit ends 0xff.
// - Channel 26 temperature, 27 bandgap.
module adc_conversion_sequencer #(
    parameter int unsigned ASYNC_DIV = 4
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [adc_seq_pkg::PADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic hw_trigger_input,
    input wire logic alternate_clock_input,
    input wire logic cmp_above,
    input wire logic wait_mode,
    input wire logic stop_shallow,
    input wire logic stop_deep,
    output logic conv_irq,
    output logic sample_en,
    output logic [9:0] dac_code,
    output logic [4:0] analog_channel,
    output logic temp_sensor_en,
    output logic bandgap_en,
    output logic async_clk_en,
    output logic low_power_en
);
    import adc_seq_pkg::*;

    // The async divider counter is eight bits wide.
    if (ASYNC_DIV < 2 || ASYNC_DIV > 256) begin : g_bad_div
        $error("ASYNC_DIV must lie between 2 and 256");
    end
    localparam logic [7:0] ASYNC_TOP = 8'(ASYNC_DIV - 1);

    seq_state_t state_r, st_nxt;
    logic flag_r, irq_en_r, cont_r, hwt_en_r, cmp_en_r, cmp_gt_r, hi_pend_r;
    logic [4:0] chan_r, cnt_r;
    logic [7:0] cfg_r, async_cnt_r;
    logic [9:0] cv_r, res_r;
    logic [3:0] bit_r;
    logic [2:0] div_cnt_r;
    logic half_r, alt_q_r, hwt_q_r, stop_q_r;
    logic [7:0] rd_byte;

    // Bus decode; only aligned words inside the map are claimed.
    wire logic [9:0] idx = paddr[PADDR_W-1:2];
    wire logic mapped = (paddr[1:0] == 2'h0) && (idx >= IDX_SC1) && (idx <= IDX_CFG);
    wire logic xfer = psel && penable && pready;
    wire logic wr_ok = xfer && pwrite && mapped;
    wire logic wr_sc1 = wr_ok && (idx == IDX_SC1);
    wire logic wr_sc2 = wr_ok && (idx == IDX_SC2);
    wire logic wr_cfg = wr_ok && (idx == IDX_CFG);
    wire logic wr_cvh = wr_ok && (idx == IDX_CVH);
    wire logic wr_cvl = wr_ok && (idx == IDX_CVL);
    wire logic wr_mode = wr_sc2 || wr_cfg || wr_cvh || wr_cvl;
    wire logic rd_hi = xfer && !pwrite && (idx == IDX_RESH) && mapped;
    wire logic rd_lo = xfer && !pwrite && (idx == IDX_RESL) && mapped;

    // Configuration fields.
    wire logic [1:0] clk_sel = cfg_r[CFG_CLK_HI:CFG_CLK_LO];
    wire logic mode10 = cfg_r[CFG_MODE_HI:CFG_MODE_LO] == MODE_10BIT;
    wire logic [2:0] div_mask = {cfg_r[CFG_DIV_HI] & cfg_r[CFG_DIV_LO], cfg_r[CFG_DIV_HI],
                                 cfg_r[CFG_DIV_HI] | cfg_r[CFG_DIV_LO]};
    wire logic active = (state_r == ST_SAMPLE) || (state_r == ST_CONV);
    wire logic in_stop = stop_shallow || stop_deep;

    // Read data selection; unused upper bits read as zero.
    always_comb begin
        case (idx)
            IDX_SC1: rd_byte = {flag_r, irq_en_r, cont_r, chan_r};
            IDX_SC2: rd_byte = {active, hwt_en_r, cmp_en_r, cmp_gt_r, 4'h0};
            IDX_RESH: rd_byte = {6'h00, res_r[9:8]};
            IDX_RESL: rd_byte = res_r[7:0];
            IDX_CVH: rd_byte = {6'h00, cv_r[9:8]};
            IDX_CVL: rd_byte = cv_r[7:0];
            IDX_CFG: rd_byte = cfg_r;
            default: rd_byte = 8'h00;
        endcase
    end

    // One wait-free access phase: data is captured in the setup cycle so it leaves a flop.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            prdata <= (psel && !penable && mapped) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
        end
    end

    // Clock source edges; pins are synchronous, so one stage gives the edge.
    // counter overflow only.
    wire logic alt_rise = alternate_clock_input && !alt_q_r;
    wire logic hwt_edge = hw_trigger_input && !hwt_q_r && !stop_deep;
    wire logic async_tick = async_clk_en && (async_cnt_r == ASYNC_TOP);
    wire logic stop_enter = in_stop && !stop_q_r && (clk_sel != CLK_ASYNC);
    logic base_tick;

    always_comb begin
        case (clk_sel)
            CLK_BUS: base_tick = 1'b1;
            CLK_HALF: base_tick = half_r;
            CLK_ALT: base_tick = alt_rise && !in_stop;
            CLK_ASYNC: base_tick = async_tick;
            default: base_tick = 1'b0;
        endcase
    end
    wire logic conv_tick = base_tick && ((div_cnt_r & div_mask) == div_mask);

    // Divider and edge history; the divider restarts whenever the converter sleeps.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            half_r <= 1'b0;
            alt_q_r <= 1'b0;
            hwt_q_r <= 1'b0;
            stop_q_r <= 1'b0;
            div_cnt_r <= 3'h0;
            async_cnt_r <= 8'h00;
        end else begin
            half_r <= !half_r;
            alt_q_r <= alternate_clock_input;
            hwt_q_r <= hw_trigger_input;
            stop_q_r <= in_stop;
            div_cnt_r <= !active ? 3'h0 : (base_tick ? div_cnt_r + 3'h1 : div_cnt_r);
            async_cnt_r <= (!async_clk_en || async_tick) ? 8'h00 : async_cnt_r + 8'h01;
        end
    end

    // Successive approximation decision on the current trial bit.
    wire logic [9:0] bit_oh = 10'h001 << bit_r;
    wire logic [9:0] sar_dec = cmp_above ? dac_code : (dac_code & ~bit_oh);
    wire logic last_bit = bit_r == (mode10 ? LSB_10BIT : LSB_8BIT);
    wire logic [9:0] res_new = mode10 ? sar_dec : {2'h0, sar_dec[9:2]};
    wire logic cmp_true = cmp_gt_r ? (res_new >= cv_r) : (res_new < cv_r);
    wire logic abort_any = wr_sc1 || wr_mode || stop_enter;
    wire logic done = (state_r == ST_CONV) && conv_tick && last_bit && !abort_any;
    wire logic blocked = mode10 && hi_pend_r;
    wire logic cmp_stop = cmp_en_r && !cmp_true && !cont_r;
    wire logic xfer_ok = done && !blocked && (!cmp_en_r || cmp_true);
    wire logic flag_nxt = xfer_ok || (flag_r && !(wr_sc1 || rd_lo));
    wire logic [4:0] sample_len = cfg_r[CFG_LSMP_BIT] ? SAMPLE_LONG : SAMPLE_SHORT;
    wire seq_state_t rest_st = hwt_en_r ? ST_ARMED : ST_IDLE;

    // Sequencer; software and stop aborts override every step.
    always_comb begin
        st_nxt = state_r;
        case (state_r)
            ST_IDLE: st_nxt = ST_IDLE;
            ST_ARMED: st_nxt = hwt_edge ? ST_SAMPLE : ST_ARMED;
            ST_SAMPLE: st_nxt = (conv_tick && cnt_r == 5'h00) ? ST_CONV : ST_SAMPLE;
            ST_CONV: begin
                if (done) begin
                    if (cmp_stop) begin
                        st_nxt = rest_st;
                    end else if (!xfer_ok || cont_r) begin
                        st_nxt = ST_SAMPLE;
                    end else begin
                        st_nxt = rest_st;
                    end
                end
            end
            default: st_nxt = ST_IDLE;
        endcase
        if (wr_sc1) begin
            if (pwdata[4:0] == CH_DISABLED) begin
                st_nxt = ST_IDLE;
            end else begin
                st_nxt = hwt_en_r ? ST_ARMED : ST_SAMPLE;
            end
        // abort on mode change or stop.
        end else if (wr_mode || stop_enter) begin
            st_nxt = ST_IDLE;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= st_nxt;
        end
    end

    // sample count then approximation; both reload outside their own state.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cnt_r <= SAMPLE_SHORT;
            bit_r <= SAR_MSB;
            dac_code <= SAR_START;
        end else begin
            if (state_r == ST_SAMPLE && !wr_sc1) begin
                cnt_r <= conv_tick ? cnt_r - 5'h01 : cnt_r;
            end else begin
                cnt_r <= sample_len;
            end
            if (state_r == ST_CONV && conv_tick && !last_bit) begin
                bit_r <= bit_r - 4'h1;
                dac_code <= sar_dec | (bit_oh >> 1);
            end else if (state_r != ST_CONV || done) begin
                bit_r <= SAR_MSB;
                dac_code <= SAR_START;
            end
        end
    end

    // Software-visible control registers.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            irq_en_r <= SC1_RST[SC1_IEN_BIT];
            cont_r <= SC1_RST[SC1_CONT_BIT];
            chan_r <= SC1_RST[4:0];
            hwt_en_r <= 1'b0;
            cmp_en_r <= 1'b0;
            cmp_gt_r <= 1'b0;
            cfg_r <= CFG_RST;
            cv_r <= 10'h000;
        end else begin
            if (wr_sc1) begin
                irq_en_r <= pwdata[SC1_IEN_BIT];
                cont_r <= pwdata[SC1_CONT_BIT];
                chan_r <= pwdata[4:0];
            end
            if (wr_sc2) begin
                hwt_en_r <= pwdata[SC2_HWT_BIT];
                cmp_en_r <= pwdata[SC2_CMPEN_BIT];
                cmp_gt_r <= pwdata[SC2_CMPGT_BIT];
            end
            if (wr_cfg) begin
                cfg_r <= pwdata[7:0];
            end
            if (wr_cvh) begin
                cv_r[9:8] <= pwdata[1:0];
            end
            if (wr_cvl) begin
                cv_r[7:0] <= pwdata[7:0];
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            res_r <= RES_RST;
            flag_r <= 1'b0;
            hi_pend_r <= 1'b0;
            conv_irq <= 1'b0;
        end else begin
            if (xfer_ok) begin
                res_r <= res_new;
            end
            // Flag set wins over a clear in the same cycle.
            flag_r <= flag_nxt;
            hi_pend_r <= (rd_hi && mode10) || (hi_pend_r && !rd_lo);
            conv_irq <= (xfer_ok && irq_en_r) || (conv_irq && flag_nxt && irq_en_r);
        end
    end

    // Analog side controls, registered; sample and async clock enables from the next state.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sample_en <= 1'b0;
            async_clk_en <= 1'b0;
            analog_channel <= SC1_RST[4:0];
            temp_sensor_en <= 1'b0;
            bandgap_en <= 1'b0;
            low_power_en <= 1'b0;
        end else begin
            sample_en <= st_nxt == ST_SAMPLE;
            async_clk_en <= (clk_sel == CLK_ASYNC) && (st_nxt == ST_SAMPLE || st_nxt == ST_CONV);
            analog_channel <= chan_r;
            temp_sensor_en <= chan_r == CH_TEMP;
            bandgap_en <= chan_r == CH_BANDGAP;
            low_power_en <= cfg_r[CFG_LP_BIT];
        end
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    property p_flag_set;
        xfer_ok |=> flag_r && res_r == $past(res_new);
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("flag or result missing");

    property p_irq;
        xfer_ok && irq_en_r |=> conv_irq && flag_r;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt not raised");

    property p_block;
        done && blocked |=> $stable(res_r) && state_r != ST_CONV;
    endproperty
    a_block: assert property (p_block) else $error("blocked result written");

    property p_cmp_stop;
        done && cmp_stop |=> (state_r == ST_IDLE || state_r == ST_ARMED) && $stable(res_r);
    endproperty
    a_cmp_stop: assert property (p_cmp_stop) else $error("compare false kept going");

    property p_restart;
        done && blocked && !cmp_stop |=> state_r == ST_SAMPLE ##1 state_r == ST_SAMPLE;
    endproperty
    a_restart: assert property (p_restart) else $error("blocked without restart");

    property p_sc1_start;
        wr_sc1 && pwdata[4:0] != CH_DISABLED && !hwt_en_r |=> state_r == ST_SAMPLE;
    endproperty
    a_sc1_start: assert property (p_sc1_start) else $error("write did not restart");

    property p_mode_abort;
        wr_mode && !wr_sc1 |=> state_r == ST_IDLE && $stable(res_r);
    endproperty
    a_mode_abort: assert property (p_mode_abort) else $error("mode write not aborting");

    property p_stop_abort;
        stop_enter && !wr_sc1 |=> state_r == ST_IDLE;
    endproperty
    a_stop_abort: assert property (p_stop_abort) else $error("stop did not abort");

    property p_async_idle;
        state_r == ST_IDLE |-> !async_clk_en && !sample_en;
    endproperty
    a_async_idle: assert property (p_async_idle) else $error("clock on while idle");

    property p_alt_stop;
        clk_sel == CLK_ALT && in_stop |-> !base_tick;
    endproperty
    a_alt_stop: assert property (p_alt_stop) else $error("alternate ticked in stop");

    property p_trigger;
        state_r == ST_ARMED && hwt_edge && !abort_any |=> state_r == ST_SAMPLE && sample_en;
    endproperty
    a_trigger: assert property (p_trigger) else $error("trigger ignored");

    property p_8bit;
        xfer_ok && !mode10 |=> res_r[9:8] == 2'h0;
    endproperty
    a_8bit: assert property (p_8bit) else $error("8-bit result too wide");

    c_transfer: cover property (xfer_ok);
    c_blocked: cover property (done && blocked);
    c_hw_start: cover property (state_r == ST_ARMED && hwt_edge);
    c_cmp_stop: cover property (done && cmp_stop);
endmodule
`default_nettype wire

// ===== verilog/adc_seq_pkg.sv
`default_nettype none
package adc_seq_pkg;
    // Bus address width and register word indices; byte address is four times the index.
    localparam int PADDR_W = 12;
    localparam logic [9:0] IDX_SC1 = 10'h010;
    localparam logic [9:0] IDX_SC2 = 10'h011;
    localparam logic [9:0] IDX_RESH = 10'h012;
    localparam logic [9:0] IDX_RESL = 10'h013;
    localparam logic [9:0] IDX_CVH = 10'h014;
    localparam logic [9:0] IDX_CVL = 10'h015;
    localparam logic [9:0] IDX_CFG = 10'h016;
    // Field positions of the first status and control register.
    localparam int SC1_FLAG_BIT = 7;
    localparam int SC1_IEN_BIT = 6;
    localparam int SC1_CONT_BIT = 5;
    // Field positions of the second status and control register.
    localparam int SC2_ACT_BIT = 7;
    localparam int SC2_HWT_BIT = 6;
    localparam int SC2_CMPEN_BIT = 5;
    localparam int SC2_CMPGT_BIT = 4;
    // Field positions of the configuration register.
    localparam int CFG_LP_BIT = 7;
    localparam int CFG_DIV_HI = 6;
    localparam int CFG_DIV_LO = 5;
    localparam int CFG_LSMP_BIT = 4;
    localparam int CFG_MODE_HI = 3;
    localparam int CFG_MODE_LO = 2;
    localparam int CFG_CLK_HI = 1;
    localparam int CFG_CLK_LO = 0;
    // Encodings of channel, resolution and clock source.
    localparam logic [4:0] CH_DISABLED = 5'h1f;
    localparam logic [4:0] CH_TEMP = 5'h1a;
    localparam logic [4:0] CH_BANDGAP = 5'h1b;
    localparam logic [1:0] MODE_8BIT = 2'h0;
    localparam logic [1:0] MODE_10BIT = 2'h2;
    localparam logic [1:0] CLK_BUS = 2'h0;
    localparam logic [1:0] CLK_HALF = 2'h1;
    localparam logic [1:0] CLK_ALT = 2'h2;
    localparam logic [1:0] CLK_ASYNC = 2'h3;
    // Reset values and approximation bit positions.
    localparam logic [7:0] SC1_RST = 8'h1f;
    localparam logic [7:0] CFG_RST = 8'h00;
    localparam logic [9:0] RES_RST = 10'h000;
    localparam logic [9:0] SAR_START = 10'h200;
    localparam logic [3:0] SAR_MSB = 4'h9;
    localparam logic [3:0] LSB_10BIT = 4'h0;
    localparam logic [3:0] LSB_8BIT = 4'h2;
    // Sample period in conversion clock ticks, short and long.
    localparam logic [4:0] SAMPLE_SHORT = 5'h04;
    localparam logic [4:0] SAMPLE_LONG = 5'h18;
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_ARMED = 4'b0010,
        ST_SAMPLE = 4'b0100,
        ST_CONV = 4'b1000
    } seq_state_t;
endpackage
`default_nettype wire

// ===== verification/adc_conversion_sequencer_bench.sv
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_sequencer_bench;
    import adc_seq_pkg::*;
    logic core_clk, rst, psel, penable, pwrite, hw_trigger_input, alternate_clock_input;
    logic wait_mode, stop_shallow, stop_deep, pready, pslverr, conv_irq, sample_en;
    logic temp_sensor_en, bandgap_en, async_clk_en, low_power_en;
    logic [PADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, v;
    logic [9:0] dac_code, target, res;
    logic [4:0] analog_channel;
    wire logic cmp_above;
    int miscompares = 0;
    int checks_done = 0;

    // The comparator is analog, so it answers within the cycle of each trial.
    assign cmp_above = (target >= dac_code);

    adc_conversion_sequencer #(.ASYNC_DIV(2)) adc_conversion_sequencer_inst (
        .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .hw_trigger_input(hw_trigger_input), .alternate_clock_input(alternate_clock_input),
        .cmp_above(cmp_above), .wait_mode(wait_mode), .stop_shallow(stop_shallow),
        .stop_deep(stop_deep), .conv_irq(conv_irq), .sample_en(sample_en),
        .dac_code(dac_code), .analog_channel(analog_channel), .temp_sensor_en(temp_sensor_en),
        .bandgap_en(bandgap_en), .async_clk_en(async_clk_en), .low_power_en(low_power_en));

    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    // The alternate clock runs at half the core rate so its ticks are seen.
    always @(posedge core_clk) begin
        alternate_clock_input <= ~alternate_clock_input;
    end

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One APB transfer; the request is held until pready is sampled high.
    task automatic xfer(input logic wr, input logic [9:0] idx, input logic [7:0] wd,
                        output logic [31:0] rd, output logic err);
        int n;
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h000000, wd};
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        if (n >= 20) begin
            miscompares++;
            $display("ERROR pready expected 1 seen none");
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [9:0] idx, input logic [7:0] d);
        logic [31:0] r;
        logic e;
        xfer(1'b1, idx, d, r, e);
    endtask

    task automatic rd(input logic [9:0] idx, output logic [31:0] r);
        logic e;
        xfer(1'b0, idx, 8'h00, r, e);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    // Poll the complete flag with a bounded number of reads.
    task automatic wait_done();
        int n;
        logic [31:0] r;
        n = 0;
        r = '0;
        while (r[SC1_FLAG_BIT] !== 1'b1 && n < 300) begin
            rd(IDX_SC1, r);
            n++;
        end
        check("complete flag", {31'h0, r[SC1_FLAG_BIT]}, 32'h1);
    endtask

    task automatic get_result(output logic [9:0] r);
        logic [31:0] h, l;
        rd(IDX_RESH, h);
        rd(IDX_RESL, l);
        r = {h[1:0], l[7:0]};
    endtask

    task automatic check_idle(input logic [9:0] keep);
        logic [9:0] r;
        idle(60);
        rd(IDX_SC1, v);
        check("flag after abort", {31'h0, v[SC1_FLAG_BIT]}, 32'h0);
        rd(IDX_SC2, v);
        check("active after abort", {31'h0, v[SC2_ACT_BIT]}, 32'h0);
        get_result(r);
        check("kept result", {22'h0, r}, {22'h0, keep});
    endtask

    initial begin
        repeat (60000) @(posedge core_clk);
        miscompares++;
        $display("ERROR run length expected end seen hang");
        wrap_up();
    end

    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        hw_trigger_input = 1'b0;
        alternate_clock_input = 1'b0;
        wait_mode = 1'b0;
        stop_shallow = 1'b0;
        stop_deep = 1'b0;
        target = 10'h000;
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        rd(IDX_SC1, v);
        check("sc1 reset", v, {24'h0, SC1_RST});
        rd(IDX_CFG, v);
        check("cfg reset", v, {24'h0, CFG_RST});
        get_result(res);
        check("result reset", {22'h0, res}, {22'h0, RES_RST});
        xfer(1'b0, 10'h020, 8'h00, v, res[0]);
        check("unmapped error", {31'h0, res[0]}, 32'h1);
        wr(IDX_RESL, 8'h55);
        rd(IDX_RESL, v);
        check("read-only result", v, 32'h0);
        // Every clock source converts a 10-bit code with the interrupt enabled.
        // results are read only after the flag is seen.
        for (int s = 0; s < 4; s++) begin
            target <= 10'h2a5 ^ 10'(s * 97);
            wr(IDX_CFG, {6'h02, 2'(s)});
            wr(IDX_SC1, 8'h41);
            idle(2);
            check("async enable busy", {31'h0, async_clk_en}, {31'h0, s == 3});
            wait_done();
            check("irq on complete", {31'h0, conv_irq}, 32'h1);
            get_result(res);
            // The interrupt drops at the low-byte read edge, so let that edge settle.
            idle(1);
            check("10-bit result", {22'h0, res}, {22'h0, 10'h2a5 ^ 10'(s * 97)});
            check("irq cleared", {31'h0, conv_irq}, 32'h0);
            check("async enable idle", {31'h0, async_clk_en}, 32'h0);
        end
        // An 8-bit result tops out at 0xff and a high read does not block it.
        target <= 10'h3ff;
        wr(IDX_CFG, 8'h00);
        wr(IDX_SC1, 8'h01);
        rd(IDX_RESH, v);
        wait_done();
        check("irq disabled", {31'h0, conv_irq}, 32'h0);
        get_result(res);
        check("8-bit full scale", {22'h0, res}, 32'h0ff);
        // A split read in 10-bit mode discards results until the low byte is read.
        target <= 10'h123;
        wr(IDX_CFG, 8'h08);
        wr(IDX_SC1, 8'h01);
        rd(IDX_RESH, v);
        idle(100);
        rd(IDX_SC1, v);
        check("blocked flag", {31'h0, v[SC1_FLAG_BIT]}, 32'h0);
        rd(IDX_SC2, v);
        check("restart after block", {31'h0, v[SC2_ACT_BIT]}, 32'h1);
        rd(IDX_RESL, v);
        wait_done();
        get_result(res);
        check("after unblock", {22'h0, res}, 32'h123);
        // Mode writes and stop entry abort and keep the last result.
        target <= 10'h0f0;
        wr(IDX_SC1, 8'h01);
        wr(IDX_CVH, 8'h00);
        check_idle(10'h123);
        wr(IDX_SC1, 8'h01);
        stop_shallow <= 1'b1;
        idle(3);
        stop_shallow <= 1'b0;
        check_idle(10'h123);
        // Channel codes steer the internal sources; all ones disables.
        for (int c = 26; c < 28; c++) begin
            wr(IDX_SC1, 8'(c));
            idle(2);
            check("channel out", {27'h0, analog_channel}, c);
            check("temp sensor", {31'h0, temp_sensor_en}, {31'h0, c == 26});
            check("bandgap", {31'h0, bandgap_en}, {31'h0, c == 27});
        end
        wr(IDX_SC1, {3'h0, CH_DISABLED});
        check_idle(10'h123);
        // A hardware trigger starts the armed conversion.
        wr(IDX_SC2, 8'h40);
        wr(IDX_SC1, 8'h01);
        idle(60);
        rd(IDX_SC1, v);
        check("armed no flag", {31'h0, v[SC1_FLAG_BIT]}, 32'h0);
        hw_trigger_input <= 1'b1;
        idle(2);
        hw_trigger_input <= 1'b0;
        wait_done();
        get_result(res);
        check("triggered result", {22'h0, res}, 32'h0f0);
        // A single conversion with a false compare ends with no transfer.
        wr(IDX_SC2, 8'h20);
        wr(IDX_CVH, 8'h00);
        wr(IDX_CVL, 8'h00);
        wr(IDX_SC1, 8'h01);
        check_idle(10'h0f0);
        wr(IDX_CFG, 8'h98);
        // The pin follows the register one edge later.
        idle(2);
        check("low power", {31'h0, low_power_en}, 32'h1);
        wr(IDX_SC2, 8'h00);
        wr(IDX_SC1, 8'h01);
        idle(2);
        check("sampling", {31'h0, sample_en}, 32'h1);
        rst <= 1'b1;
        idle(2);
        rst <= 1'b0;
        get_result(res);
        check("result after reset", {22'h0, res}, 32'h0);
        rd(IDX_SC1, v);
        check("sc1 after reset", v, {24'h0, SC1_RST});
        wrap_up();
    end
endmodule
`default_nettype wire
